// ---- hdl/rwc_defs.vh ----
// Constants for the reset and wake-up controller
`ifndef RWC_DEFS_VH
`define RWC_DEFS_VH

// Register word indices, byte address is index times four
`define RWC_IDX_TIMER      5'h01
`define RWC_IDX_PCL        5'h02
`define RWC_IDX_STATUS     5'h03
`define RWC_IDX_WPORT      5'h06
`define RWC_IDX_SPARE      5'h0A
`define RWC_IDX_PD         5'h0B
`define RWC_IDX_OD         5'h0C
`define RWC_IDX_PH         5'h0D
`define RWC_IDX_WDC        5'h0E
`define RWC_IDX_IMR        5'h0F
`define RWC_IDX_IFR        5'h10
`define RWC_IDX_NDIR       5'h11
`define RWC_IDX_WDIR       5'h12
`define RWC_IDX_TPC        5'h13
`define RWC_IDX_STATE      5'h14

// Field positions
`define RWC_SR_T           4
`define RWC_SR_P           3
`define RWC_WDC_EN         7
`define RWC_WDC_EIS        6
`define RWC_WDC_ROC        4
`define RWC_TPC_INT        6
`define RWC_TPC_PAB        3
`define RWC_IFR_PIN_CHANGE_INT_FLAG       1
`define RWC_IMR_ICIE       1

// Reset values
`define RWC_RST_TPC        8'hBF
`define RWC_RST_ONES       8'hFF
`define RWC_RST_ZERO       8'h00
`define RWC_RST_DIR        8'hFF
`define RWC_LOW3_KEEP      8'hF8
`define RWC_INT_VECTOR     8'h08

// Timing
`define RWC_CLK_PERIOD_NS  5
`define RWC_RC_TICK_NS     1000
`define RWC_OST_MS         18
`define RWC_WDT_MS         18
`define RWC_RC_DIV         (`RWC_RC_TICK_NS / `RWC_CLK_PERIOD_NS)
`define RWC_OST_TICKS      (`RWC_OST_MS * 1000000 / `RWC_RC_TICK_NS)
`define RWC_WDT_TICKS      (`RWC_WDT_MS * 1000000 / `RWC_RC_TICK_NS)

`endif

// ---- hdl/rwc_reset_wake.v ----
// Reset, sleep and wake-up controller with Wishbone register access
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "rwc_defs.vh"

// How it works
// - Reset from power, pin low, watchdog
// - Hold reset one start-up period
// - Oscillator enabled throughout reset
// - Program counter cleared on reset
// - All port pins made inputs
// - Watchdog and prescaler cleared on reset
// - Top status bits cleared only on power-on
// - Timer control all ones except bit 6
// - Spare, pull-down, pull-high set to ones
// - Open-drain control cleared on reset
// - Watchdog enable set, bits 6,4 cleared
// - Low three flag and mask bits cleared
// - Sleep halts; watchdog cleared, keeps running
// - Wake by pin, watchdog, port change
// - Time-out and power-down flags show cause
// - Port-change wake resumes, vector if enabled
// - Any wake re-enables the watchdog
// - Flag values per event table
module rwc_reset_wake #(
    parameter [15:0] RC_DIV     = `RWC_RC_DIV,    // Clock cycles per watchdog oscillator tick
    parameter [23:0] HOLD_TICKS = `RWC_OST_TICKS, // Oscillator ticks of the start-up hold
    parameter [23:0] WDT_TICKS  = `RWC_WDT_TICKS  // Oscillator ticks of one watchdog period
) (
    input  wire        clk_i,                     // Core clock, 200 MHz
    input  wire        rst_i,                     // Power-on reset, active high
    input  wire        wb_cyc_i,                  // Wishbone cycle
    input  wire        wb_stb_i,                  // Wishbone strobe
    input  wire        wb_we_i,                   // Wishbone write enable
    input  wire [7:0]  wb_adr_i,                  // Wishbone byte address
    input  wire [3:0]  wb_sel_i,                  // Wishbone byte selects
    input  wire [31:0] wb_dat_i,                  // Wishbone write data
    output reg  [31:0] wb_dat_o,                  // Wishbone read data
    output reg         wb_ack_o,                  // Wishbone acknowledge
    input  wire        ext_rst_n_i,               // External reset pin, active low
    input  wire [7:0]  wide_port_i,               // Wide port input levels
    input  wire        sleep_instr_i,             // Sleep instruction executed
    input  wire        watchdog_clear_instr_i,    // Watchdog clear instruction executed
    input  wire        global_int_en_i,           // Global interrupt state
    output reg         core_hold_o,               // Core held in reset
    output reg         osc_en_o,                  // Main oscillator enable
    output reg         sleep_o,                   // Core in power-down
    output reg         pc_load_o,                 // Pulse, load program counter
    output reg  [7:0]  pc_value_o,                // Value to load
    output reg  [7:0]  narrow_port_direction_o,   // 1 = input
    output reg  [7:0]  wide_port_direction_o,     // 1 = input
    output reg  [7:0]  timer_prescale_control_o,  // Timer and prescaler control
    output reg  [7:0]  spare_control_register_o,  // Spare control
    output reg  [7:0]  pull_down_control_o,       // Active-low pull-down enables
    output reg  [7:0]  open_drain_control_o,      // Open-drain enables
    output reg  [7:0]  pull_high_control_o,       // Active-low pull-high enables
    output reg  [7:0]  watchdog_control_o,        // Watchdog control
    output reg  [7:0]  interrupt_mask_register_o, // Interrupt masks
    output reg  [7:0]  interrupt_flag_register_o, // Interrupt flags
    output reg  [7:0]  processor_status_o,        // Status register
    output reg  [7:0]  timer_count_o              // Timer count
);

    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_HOLD  = 2'b01;
    localparam [1:0] ST_SLEEP = 2'b10;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [15:0] rc_div_r;
    reg         rc_tick_r;
    reg  [23:0] hold_cnt_r;
    reg  [23:0] wdt_cnt_r;
    reg  [7:0]  presc_r;
    reg  [7:0]  pcl_r;
    reg  [7:0]  wsnap_r;
    reg  [7:0]  rd_mux;

    wire        active     = (state_r == ST_RUN) || (state_r == ST_SLEEP);
    wire        pin_low    = ~ext_rst_n_i;
    wire        prescaler_assign_bit        = timer_prescale_control_o[`RWC_TPC_PAB];
    wire [7:0]  presc_mask = (8'h01 << timer_prescale_control_o[2:0]) - 8'h01;
    wire        wdt_wrap   = rc_tick_r && (wdt_cnt_r == WDT_TICKS - 24'h000001);
    wire        presc_hit  = ~prescaler_assign_bit || ((presc_r & presc_mask) == presc_mask);
    wire        wdt_on     = watchdog_control_o[`RWC_WDC_EN];
    wire        wdt_tmo    = wdt_on && wdt_wrap && presc_hit;
    wire [7:0]  int_pin    = {7'h00, watchdog_control_o[`RWC_WDC_EIS]};
    wire        port_chg   = |((wide_port_i ^ wsnap_r) & wide_port_direction_o & ~int_pin);
    wire        pin_change_int_flag_set   = port_chg && interrupt_mask_register_o[`RWC_IMR_ICIE];
    wire        rst_pin    = active && pin_low;
    wire        rst_wdt    = active && ~pin_low && wdt_tmo;
    wire        any_rst    = rst_i || rst_pin || rst_wdt;
    wire        wake_chg   = (state_r == ST_SLEEP) && ~any_rst && interrupt_flag_register_o[`RWC_IFR_PIN_CHANGE_INT_FLAG]
                             && interrupt_mask_register_o[`RWC_IMR_ICIE];
    wire        hold_done  = (state_r == ST_HOLD) && ~pin_low && rc_tick_r
                             && (hold_cnt_r == HOLD_TICKS - 24'h000001);
    wire        do_sleep   = (state_r == ST_RUN) && ~any_rst && sleep_instr_i;
    wire        do_watchdog_clear_instr    = (state_r == ST_RUN) && ~any_rst && ~sleep_instr_i && watchdog_clear_instr_i;
    wire        bus_req    = wb_cyc_i && wb_stb_i && ~wb_ack_o;
    wire        bus_wr     = bus_req && wb_we_i && wb_sel_i[0] && (state_r != ST_HOLD) && ~any_rst;
    wire [4:0]  idx        = wb_adr_i[6:2];
    wire [7:0]  wd         = wb_dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Watchdog oscillator tick, free running from the core clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_div_r  <= 16'h0000;
            rc_tick_r <= 1'b0;
        end else if (rc_div_r == RC_DIV - 16'h0001) begin
            rc_div_r  <= 16'h0000;
            rc_tick_r <= 1'b1;
        end else begin
            rc_div_r  <= rc_div_r + 16'h0001;
            rc_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always @* begin
        state_nxt = state_r;
        if (any_rst) begin
            state_nxt = ST_HOLD;
        end else begin
            case (state_r)
                ST_RUN:   if (do_sleep) state_nxt = ST_SLEEP;
                ST_SLEEP: if (wake_chg) state_nxt = ST_RUN;
                ST_HOLD:  if (hold_done) state_nxt = ST_RUN;
                default:  state_nxt = ST_HOLD;
            endcase
        end
    end

    // State and control outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= ST_HOLD;
            core_hold_o <= 1'b1;
            osc_en_o    <= 1'b1;
            sleep_o     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            core_hold_o <= (state_nxt == ST_HOLD);
            osc_en_o    <= (state_nxt != ST_SLEEP);
            sleep_o     <= (state_nxt == ST_SLEEP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up hold counter on the watchdog oscillator
    always @(posedge clk_i) begin
        if (rst_i || (state_r != ST_HOLD) || pin_low) begin
            hold_cnt_r <= 24'h000000;
        end else if (rc_tick_r) begin
            hold_cnt_r <= hold_cnt_r + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog counter and shared prescaler
    always @(posedge clk_i) begin
        if (rst_i || any_rst || (state_r == ST_HOLD)) begin
            wdt_cnt_r <= 24'h000000;
            presc_r   <= 8'h00;
        end else if (do_sleep || do_watchdog_clear_instr) begin
            wdt_cnt_r <= 24'h000000;
            if (prescaler_assign_bit) begin
                presc_r <= 8'h00;
            end
        end else if (bus_wr && (idx == `RWC_IDX_TIMER) && ~prescaler_assign_bit) begin
            presc_r <= 8'h00;
        end else if (wdt_on && rc_tick_r) begin
            wdt_cnt_r <= wdt_wrap ? 24'h000000 : wdt_cnt_r + 24'h000001;
            if (wdt_wrap && prescaler_assign_bit) begin
                presc_r <= wdt_tmo ? 8'h00 : presc_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter load requests
    always @(posedge clk_i) begin
        if (rst_i) begin
            pc_load_o  <= 1'b0;
            pc_value_o <= 8'h00;
        end else if (hold_done) begin
            pc_load_o  <= 1'b1;
            pc_value_o <= 8'h00;
        end else if (wake_chg && global_int_en_i) begin
            pc_load_o  <= 1'b1;
            pc_value_o <= `RWC_INT_VECTOR;
        end else begin
            pc_load_o  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file with reset values per cause
    always @(posedge clk_i) begin
        if (any_rst) begin
            pcl_r                    <= 8'h00;
            timer_count_o            <= 8'h00;
            narrow_port_direction_o  <= `RWC_RST_DIR;
            wide_port_direction_o    <= `RWC_RST_DIR;
            timer_prescale_control_o <= `RWC_RST_TPC;
            spare_control_register_o <= `RWC_RST_ONES;
            pull_down_control_o      <= `RWC_RST_ONES;
            pull_high_control_o      <= `RWC_RST_ONES;
            open_drain_control_o     <= `RWC_RST_ZERO;
            watchdog_control_o[`RWC_WDC_EN]  <= 1'b1;
            watchdog_control_o[`RWC_WDC_EIS] <= 1'b0;
            watchdog_control_o[`RWC_WDC_ROC] <= 1'b0;
            interrupt_flag_register_o <= interrupt_flag_register_o & `RWC_LOW3_KEEP;
            interrupt_mask_register_o <= interrupt_mask_register_o & `RWC_LOW3_KEEP;
            if (rst_i) begin
                processor_status_o[7:5] <= 3'b000;
                processor_status_o[`RWC_SR_T] <= 1'b1;
                processor_status_o[`RWC_SR_P] <= 1'b1;
                watchdog_control_o[5]   <= 1'b0;
                watchdog_control_o[3:0] <= 4'h0;
                wsnap_r                 <= 8'h00;
                interrupt_flag_register_o <= 8'h00;
                interrupt_mask_register_o <= 8'h00;
                processor_status_o[2:0] <= 3'b000;
            end else if (rst_wdt) begin
                processor_status_o[`RWC_SR_T] <= 1'b0;
                if (state_r == ST_SLEEP) begin
                    processor_status_o[`RWC_SR_P] <= 1'b0;
                end
            end else if (state_r == ST_SLEEP) begin
                processor_status_o[`RWC_SR_T] <= 1'b1;
                processor_status_o[`RWC_SR_P] <= 1'b0;
            end
        end else begin
            // Sleep, watchdog clear and wake update the status flags
            if (do_sleep || wake_chg) begin
                processor_status_o[`RWC_SR_T] <= 1'b1;
                processor_status_o[`RWC_SR_P] <= 1'b0;
            end else if (do_watchdog_clear_instr) begin
                processor_status_o[`RWC_SR_T] <= 1'b1;
                processor_status_o[`RWC_SR_P] <= 1'b1;
            end
            if (wake_chg) begin
                watchdog_control_o[`RWC_WDC_EN] <= 1'b1;
                if (global_int_en_i) begin
                    pcl_r <= `RWC_INT_VECTOR;
                end
            end
            // Snapshot of the wide port on each read of its data
            if (bus_req && ~wb_we_i && (idx == `RWC_IDX_WPORT)) begin
                wsnap_r <= wide_port_i;
            end
            if (bus_wr) begin
                case (idx)
                    `RWC_IDX_TIMER:  timer_count_o <= wd;
                    `RWC_IDX_PCL:    pcl_r <= wd;
                    `RWC_IDX_STATUS: processor_status_o <= {wd[7:5], processor_status_o[4:3], wd[2:0]};
                    `RWC_IDX_SPARE:  spare_control_register_o <= wd;
                    `RWC_IDX_PD:     pull_down_control_o <= wd;
                    `RWC_IDX_OD:     open_drain_control_o <= wd;
                    `RWC_IDX_PH:     pull_high_control_o <= wd;
                    `RWC_IDX_WDC:    if (~wake_chg) watchdog_control_o <= wd;
                    `RWC_IDX_IMR:    interrupt_mask_register_o <= wd;
                    `RWC_IDX_IFR:    interrupt_flag_register_o <= wd;
                    `RWC_IDX_NDIR:   narrow_port_direction_o <= wd;
                    `RWC_IDX_WDIR:   wide_port_direction_o <= wd;
                    `RWC_IDX_TPC:    timer_prescale_control_o <= wd;
                    default:         pcl_r <= pcl_r;
                endcase
            end
            // Port change flag, set wins over a clearing write
            if (pin_change_int_flag_set) begin
                interrupt_flag_register_o[`RWC_IFR_PIN_CHANGE_INT_FLAG] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data select
    always @* begin
        case (idx)
            `RWC_IDX_TIMER:  rd_mux = timer_count_o;
            `RWC_IDX_PCL:    rd_mux = pcl_r;
            `RWC_IDX_STATUS: rd_mux = processor_status_o;
            `RWC_IDX_WPORT:  rd_mux = wide_port_i;
            `RWC_IDX_SPARE:  rd_mux = spare_control_register_o;
            `RWC_IDX_PD:     rd_mux = pull_down_control_o;
            `RWC_IDX_OD:     rd_mux = open_drain_control_o;
            `RWC_IDX_PH:     rd_mux = pull_high_control_o;
            `RWC_IDX_WDC:    rd_mux = watchdog_control_o;
            `RWC_IDX_IMR:    rd_mux = interrupt_mask_register_o;
            `RWC_IDX_IFR:    rd_mux = interrupt_flag_register_o;
            `RWC_IDX_NDIR:   rd_mux = narrow_port_direction_o;
            `RWC_IDX_WDIR:   rd_mux = wide_port_direction_o;
            `RWC_IDX_TPC:    rd_mux = timer_prescale_control_o;
            `RWC_IDX_STATE:  rd_mux = {6'h00, state_r};
            default:         rd_mux = 8'h00;
        endcase
    end

    // Wishbone handshake, one wait state, unmapped reads as zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= {24'h000000, rd_mux};
            end
        end
    end

endmodule

// ---- sim/rwc_pins_model.sv ----
// Model of the reset pin and the wide port input pins
`timescale 1ns/1ps
module rwc_pins_model (
    input  wire logic       clk_i,       // Core clock
    input  wire logic       pin_pulse_i, // Start a low pulse on the pin
    input  wire logic [7:0] port_flip_i, // Port pins to invert
    output logic            ext_rst_n_o, // Reset pin, idles high
    output logic [7:0]      wide_port_o  // Port pin levels
);
    logic [3:0] low_cnt_r;
    initial begin
        low_cnt_r = 4'h0;
        wide_port_o = 8'h5A;
    end
    // Pin held low six cycles per request
    always @(posedge clk_i) begin
        if (pin_pulse_i)
            low_cnt_r <= 4'h6;
        else if (low_cnt_r != 4'h0)
            low_cnt_r <= low_cnt_r - 4'h1;
    end
    assign ext_rst_n_o = (low_cnt_r == 4'h0);
    // Port pins move only when the bench asks, after the snapshot
    always @(posedge clk_i) wide_port_o <= wide_port_o ^ port_flip_i;
endmodule

// ---- sim/rwc_reset_wake_sva.sv ----
// Port checker of the reset and wake-up controller
`timescale 1ns/1ps
module rwc_reset_wake_sva #(
    parameter [15:0] RC_DIV     = 16'h0002, // Clocks per tick
    parameter [23:0] HOLD_TICKS = 24'h000008, // Hold ticks
    parameter [23:0] WDT_TICKS  = 24'h000010  // Watchdog ticks
) (
    input wire       clk_i,                     // Clock
    input wire       rst_i,                     // Reset
    input wire       wb_cyc_i,                  // Cycle
    input wire       wb_stb_i,                  // Strobe
    input wire       wb_ack_o,                  // Acknowledge
    input wire       ext_rst_n_i,               // Reset pin
    input wire       sleep_instr_i,             // Sleep
    input wire       watchdog_clear_instr_i,    // Watchdog clear
    input wire       core_hold_o,               // Hold
    input wire       osc_en_o,                  // Oscillator
    input wire       sleep_o,                   // Power-down
    input wire       pc_load_o,                 // PC load
    input wire [7:0] pc_value_o,                // PC value
    input wire [7:0] wide_port_direction_o,     // Directions
    input wire [7:0] timer_prescale_control_o,  // Timer control
    input wire [7:0] open_drain_control_o,      // Open-drain
    input wire [7:0] pull_high_control_o,       // Pull-high
    input wire [7:0] watchdog_control_o,        // Watchdog control
    input wire [7:0] interrupt_mask_register_o, // Masks
    input wire [7:0] interrupt_flag_register_o, // Flags
    input wire [7:0] processor_status_o         // Status
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] hold_cnt_r;
    // Cycles of hold with the pin released
    always @(posedge clk_i) hold_cnt_r <= (core_hold_o && ext_rst_n_i && !rst_i) ? hold_cnt_r + 32'h1 : 32'h0;
    sequence s_load_zero;
        ##[0:1] (pc_load_o && pc_value_o == 8'h00);
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_pin_forces_hold: assert property (!ext_rst_n_i |=> core_hold_o) else $error("pin low without hold");
    a_hold_length: assert property ($fell(core_hold_o) |-> hold_cnt_r >= (HOLD_TICKS - 1) * RC_DIV)
        else $error("hold too short");
    a_hold_pc_zero: assert property ($fell(core_hold_o) |-> s_load_zero) else $error("no load of zero");
    a_osc_in_hold: assert property (core_hold_o |-> osc_en_o) else $error("oscillator off in hold");
    a_hold_values: assert property (core_hold_o && $past(core_hold_o) |-> wide_port_direction_o == 8'hFF
        && timer_prescale_control_o == 8'hBF && open_drain_control_o == 8'h00 && pull_high_control_o == 8'hFF
        && watchdog_control_o[7:6] == 2'b10 && !watchdog_control_o[4] && interrupt_mask_register_o[2:0] == 3'h0
        && interrupt_flag_register_o[2:0] == 3'h0) else $error("register not at reset value");
    a_sleep_entry: assert property (sleep_instr_i && !sleep_o && !core_hold_o && ext_rst_n_i |=> sleep_o
        && !osc_en_o && processor_status_o[4:3] == 2'b10) else $error("bad sleep entry");
    a_wake_wdt_on: assert property ($fell(sleep_o) |-> watchdog_control_o[7]) else $error("watchdog off");
    a_clear_flags: assert property (watchdog_clear_instr_i && !core_hold_o && !sleep_o && ext_rst_n_i
        |=> processor_status_o[4:3] == 2'b11) else $error("clear flags wrong");
    a_pin_wake_flags: assert property (sleep_o && !ext_rst_n_i |-> ##[1:2] processor_status_o[4:3] == 2'b10)
        else $error("pin wake flags wrong");
endmodule
bind rwc_reset_wake rwc_reset_wake_sva #(.RC_DIV(RC_DIV), .HOLD_TICKS(HOLD_TICKS), .WDT_TICKS(WDT_TICKS)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .ext_rst_n_i(ext_rst_n_i), .sleep_instr_i(sleep_instr_i), .watchdog_clear_instr_i(watchdog_clear_instr_i),
    .core_hold_o(core_hold_o), .osc_en_o(osc_en_o), .sleep_o(sleep_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .wide_port_direction_o(wide_port_direction_o),
    .timer_prescale_control_o(timer_prescale_control_o), .open_drain_control_o(open_drain_control_o),
    .pull_high_control_o(pull_high_control_o), .watchdog_control_o(watchdog_control_o),
    .interrupt_mask_register_o(interrupt_mask_register_o), .interrupt_flag_register_o(interrupt_flag_register_o),
    .processor_status_o(processor_status_o));

// ---- sim/rwc_reset_wake_tb.sv ----
// Self-checking bench of the reset and wake-up controller
`timescale 1ns/1ps
module rwc_reset_wake_tb;
    localparam int RCD = 2;
    localparam int HT  = 8;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic        slp = 1'b0;
    logic        wclr = 1'b0;
    logic        gie = 1'b0;
    logic        pin_pulse = 1'b0;
    logic [7:0]  port_flip = 8'h00;
    logic [31:0] rdat;
    logic        ack, pin_n, hold, osc, sleep, pc_load, pcl_seen;
    logic [7:0]  wport, pc_value, wdc, stat, pcl_val;
    logic [4:0]  ridx [11] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1F};
    logic [7:0]  rval [11] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hBF, 8'h00};
    logic [4:0]  widx [8] = '{5'h0A, 5'h0C, 5'h0D, 5'h12, 5'h0B, 5'h0F, 5'h11, 5'h13};
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    initial forever #2.5 clk_i = ~clk_i;
    rwc_pins_model u_pins (.clk_i(clk_i), .pin_pulse_i(pin_pulse), .port_flip_i(port_flip), .ext_rst_n_o(pin_n),
        .wide_port_o(wport));
    rwc_reset_wake #(.RC_DIV(16'h0002), .HOLD_TICKS(24'h000008), .WDT_TICKS(24'h000010)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_rst_n_i(pin_n),
        .wide_port_i(wport), .sleep_instr_i(slp), .watchdog_clear_instr_i(wclr), .global_int_en_i(gie),
        .core_hold_o(hold), .osc_en_o(osc), .sleep_o(sleep), .pc_load_o(pc_load), .pc_value_o(pc_value),
        .narrow_port_direction_o(), .wide_port_direction_o(), .timer_prescale_control_o(),
        .spare_control_register_o(), .pull_down_control_o(), .open_drain_control_o(), .pull_high_control_o(),
        .watchdog_control_o(wdc), .interrupt_mask_register_o(), .interrupt_flag_register_o(),
        .processor_status_o(stat), .timer_count_o());
    ////////////////////////////////////////////////////////////////////////////
    // Load vector monitor and hang limit
    always @(posedge clk_i) begin
        if (pc_load === 1'b1) begin
            pcl_seen <= 1'b1;
            pcl_val <= pc_value;
        end else if (slp) begin
            pcl_seen <= 1'b0;
            pcl_val <= 8'h00;
        end
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One Wishbone classic cycle, held until ack
    task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d, output logic [7:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= {1'b0, idx, 2'b00};
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pulse(input int which);
        if (which == 0)
            slp <= 1'b1;
        else if (which == 1)
            wclr <= 1'b1;
        else
            pin_pulse <= 1'b1;
        @(posedge clk_i);
        slp <= 1'b0;
        wclr <= 1'b0;
        pin_pulse <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_hold(output int n);
        n = 0;
        while (hold !== 1'b0) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic check_resets(input logic [7:0] st, input logic [7:0] im);
        logic [7:0] q;
        for (int i = 0; i < 11; i++) begin
            xfer(1'b0, ridx[i], 8'h00, q);
            check("reset_value", q, (i == 5) ? im : rval[i]);
        end
        xfer(1'b0, 5'h03, 8'h00, q);
        check("status", q, st);
    endtask
    task automatic complete_run;
        $display("Counts: %0d compared, %0d mismatched", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic [7:0] q, r, s, m;
        r = 8'($urandom(34185));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Power-on hold and reset values
        wait_hold(n);
        check("hold_len", n >= (HT - 1) * RCD, 1'b1);
        check_resets(8'h18, 8'h00);
        $display("Test power-on done");
        // Random writes, then a pin reset
        xfer(1'b1, 5'h0E, 8'h00, q);
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            xfer(1'b1, widx[i], r, q);
            xfer(1'b0, widx[i], 8'h00, q);
            if (widx[i] == 5'h0F)
                m = r & 8'hF8;
            check("readback", q, r);
        end
        s = 8'($urandom);
        xfer(1'b1, 5'h03, s, q);
        pulse(2);
        while (pin_n !== 1'b1) @(posedge clk_i);
        wait_hold(n);
        check("pin_hold", n >= (HT - 1) * RCD && n <= HT * RCD + 2 * RCD + 2, 1'b1);
        check_resets({s[7:5], 2'b11, s[2:0]}, m);
        $display("Test pin reset done");
        // Port-change wake with and without global interrupts
        for (int g = 1; g >= 0; g--) begin
            xfer(1'b1, 5'h13, 8'h0E, q);
            pulse(1);
            xfer(1'b1, 5'h0E, 8'h00, q);
            xfer(1'b1, 5'h12, 8'hFF, q);
            xfer(1'b0, 5'h06, 8'h00, q);
            xfer(1'b1, 5'h10, 8'h00, q);
            xfer(1'b1, 5'h0F, 8'h02, q);
            gie <= g[0];
            pulse(0);
            check("sleep", {sleep, osc, stat[4:3]}, 4'b1010);
            port_flip <= 8'h01 << ($urandom % 8);
            @(posedge clk_i);
            port_flip <= 8'h00;
            repeat (4) @(posedge clk_i);
            check("awake", {hold, sleep, wdc[7], stat[4:3]}, 5'b00110);
            check("vector", {pcl_seen, pcl_val}, {g[0], g[0] ? 8'h08 : 8'h00});
        end
        $display("Test port wake done");
        // Pin and watchdog wakes from sleep, then a running time-out
        xfer(1'b1, 5'h0F, 8'h00, q);
        pulse(0);
        pulse(2);
        while (pin_n !== 1'b1) @(posedge clk_i);
        wait_hold(n);
        check("pin_wake", stat[4:3], 2'b10);
        xfer(1'b1, 5'h13, 8'h30, q);
        pulse(0);
        while (hold !== 1'b1) @(posedge clk_i);
        @(posedge clk_i);
        check("wdt_wake", stat[4:3], 2'b00);
        wait_hold(n);
        xfer(1'b1, 5'h13, 8'h30, q);
        pulse(1);
        check("wdt_clear", stat[4:3], 2'b11);
        while (hold !== 1'b1) @(posedge clk_i);
        @(posedge clk_i);
        check("wdt_run", stat[4:3], 2'b01);
        $display("Test watchdog done");
        complete_run();
    end
endmodule
